// file: design/apms_frame_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "apms_regs.svh"

module apms_frame_counter
   import apms_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clkEn,
   input  wire logic       selectPinN,
   input  wire logic       serialClkPin,
   apms_frame_if.producer  fr
);

   logic [1:0]             selSync_r;
   logic [1:0]             sclkSync_r;
   logic                   selLate_r;
   logic                   sclkLate_r;
   logic [`APMS_CNT_W-1:0] count_r;

   // Both pins are asynchronous to clock; only the second stage and its one-cycle-late copy are looked at.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         selSync_r  <= 2'h3;
         sclkSync_r <= 2'h3;
         selLate_r  <= 1'b1;
         sclkLate_r <= 1'b1;
      end
      else if (clkEn)
      begin
         selSync_r  <= {selSync_r[0], selectPinN};
         sclkSync_r <= {sclkSync_r[0], serialClkPin};
         selLate_r  <= selSync_r[1];
         sclkLate_r <= sclkSync_r[1];
      end
   end

   assign fr.selFall  = selLate_r & ~selSync_r[1];
   assign fr.selRise  = ~selLate_r & selSync_r[1];
   assign fr.selLow   = ~selSync_r[1];
   assign fr.sclkFall = sclkLate_r & ~sclkSync_r[1];
   assign fr.sclkRise = ~sclkLate_r & sclkSync_r[1];
   assign fr.edgeCount = count_r;

   // Counter saturates at a full frame so late edges do not wrap into a window.
   always_ff @(posedge clock)
   begin
      if (rst)
         count_r <= '0;
      else if (clkEn)
      begin
         if (fr.selFall)
            count_r <= '0; // R18
         else if (fr.selLow && fr.sclkFall && count_r != `APMS_CNT_FRAME)
            count_r <= count_r + `APMS_CNT_W'(1); // R18
      end
   end

endmodule // apms_frame_counter

`default_nettype wire

// file: design/apms_frame_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "apms_regs.svh"

interface apms_frame_if;
   logic                   selFall;
   logic                   selRise;
   logic                   selLow;
   logic                   sclkFall;
   logic                   sclkRise;
   logic [`APMS_CNT_W-1:0] edgeCount;

   modport producer (output selFall, output selRise, output selLow, output sclkFall,
                     output sclkRise, output edgeCount);
   modport consumer (input selFall, input selRise, input selLow, input sclkFall,
                     input sclkRise, input edgeCount);
endinterface

`default_nettype wire

// file: design/apms_pkg.sv
package apms_pkg;

   typedef enum logic [1:0]
   {
      MODE_NORMAL,
      MODE_PARTIAL,
      MODE_FULL
   } apms_mode_t;

endpackage

// file: design/apms_power_sequencer.sv
// Overview of operation
// (R1) Wake from partial power-down finishes within one dummy frame at any clock rate.
// (R2) Host waits the quiet interval after the data line releases before selecting again.
// (R3) Held sampler returns to tracking on first serial edge after select falls; the code does so only in wake-up frames.
// (R4) Host may end wake frame after tenth edge once one microsecond elapsed.
// (R5) Abort in edges two to ten while in partial power-down enters full power-down.
// (R6) After a power-down abort the remaining serial clocks are not needed.
// (R7) Leaving full power-down starts at select fall, continues if select outlasts edge ten.
// (R8) After a full wake frame the host waits the full wake delay.
// (R9) Full wake delay is 650 microseconds before a conversion.
// (R10) Start mode after supply is unknown; host runs one dummy frame first.
// (R11) Host holds partial power-down after supply with a full then an aborted frame.
// (R12) Host enters full power-down after supply with one full and two aborted frames.
// (R13) At supply power-up the sampler is already tracking.
// (R14) Select rising after edge ten keeps power, aborts frame, releases data line.
// (R15) Select rising after edge two, before ten, in normal mode enters partial power-down.
// (R16) Select rising before edge two leaves the mode unchanged.
// (R17) Frame is sixteen clocks; data releases on edge sixteen or earlier select rise.
// (R18) Edge count clears at select fall; mode chosen from count at select rise.
`timescale 1ns/1ps
`default_nettype none
`include "apms_regs.svh"

module apms_power_sequencer
   import apms_pkg::*;
#(
   parameter apms_mode_t POWERUP_MODE     = MODE_NORMAL,
   parameter int         FULL_WAKE_CYCLES = `APMS_FULL_WAKE_US * `APMS_CLK_MHZ
)
(
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire logic                      clkEn,
   input  wire logic                      selectPinN,
   input  wire logic                      serialClkPin,
   input  wire logic [`APMS_SAMPLE_W-1:0] analogSample,
   output var  logic                      serialResultOut,
   output var  logic                      serialResultOe,
   output var  apms_mode_t                powerMode,
   output var  logic                      fullyPowered,
   output var  logic                      trackActive
);

   localparam int PARTIAL_WAKE_CYCLES =
      (`APMS_PARTIAL_WAKE_NS * `APMS_CLK_MHZ + 999) / 1000;
   // Timer start and the awake register each add one cycle after select fall.
   localparam int PART_WAKE_LIMIT = PARTIAL_WAKE_CYCLES + 2;
   localparam logic [`APMS_TIMER_W-1:0] PART_TGT = `APMS_TIMER_W'(PARTIAL_WAKE_CYCLES);
   localparam logic [`APMS_TIMER_W-1:0] FULL_TGT = `APMS_TIMER_W'(FULL_WAKE_CYCLES);

   apms_frame_if fr ();

   apms_frame_counter u_counter
   (
      .clock        (clock),
      .rst          (rst),
      .clkEn        (clkEn),
      .selectPinN   (selectPinN),
      .serialClkPin (serialClkPin),
      .fr           (fr.producer)
   );

   apms_mode_t              mode_r;
   logic                    waking_r;
   logic                    wakeFromFull_r;
   logic                    awake_r;
   logic                    trackPending_r;
   logic [`APMS_TIMER_W-1:0] wakeTimer_r;
   logic [`APMS_WORD_W-1:0] word_r;
   logic [`APMS_CNT_W-1:0]  cnt;
   apms_mode_t              modeNxt;
   logic                    timerDone;

   assign cnt       = fr.edgeCount;
   assign timerDone = wakeTimer_r >= (wakeFromFull_r ? FULL_TGT : PART_TGT);

   // The mode picked at select rise from the edges seen and the mode held.
   function automatic apms_mode_t nextMode(input apms_mode_t m,
                                           input logic [`APMS_CNT_W-1:0] c);
      if (c < `APMS_CNT_POWERDOWN)
         nextMode = m; // R16
      else if (c < `APMS_CNT_KEEP)
         nextMode = (m == MODE_NORMAL) ? MODE_PARTIAL : MODE_FULL; // R15 R5
      else
         nextMode = MODE_NORMAL; // R14 R7
   endfunction

   assign modeNxt = nextMode(mode_r, cnt); // R18

   always_ff @(posedge clock)
   begin
      if (rst)
         mode_r <= POWERUP_MODE; // R10
      else if (clkEn && fr.selRise)
         mode_r <= modeNxt; // R18
   end

   // Wake bookkeeping. A glitch frame that ends early stops the wake and powers
   // back down, so a noisy select line never leaves the core half powered.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         waking_r       <= 1'b0;
         wakeFromFull_r <= 1'b0;
         awake_r        <= (POWERUP_MODE == MODE_NORMAL);
         wakeTimer_r    <= '0;
      end
      else if (clkEn)
      begin
         if (fr.selFall && mode_r != MODE_NORMAL)
         begin
            waking_r       <= 1'b1; // R7
            wakeFromFull_r <= (mode_r == MODE_FULL);
            awake_r        <= 1'b0;
            wakeTimer_r    <= '0;
         end
         else if (fr.selRise && modeNxt != MODE_NORMAL)
         begin
            waking_r <= 1'b0; // R16 R5
            awake_r  <= 1'b0;
         end
         else if (waking_r)
         begin
            wakeTimer_r <= wakeTimer_r + `APMS_TIMER_W'(1);
            if (timerDone)
            begin
               waking_r <= 1'b0; // R1 R8 R9
               awake_r  <= 1'b1;
            end
            else if (!wakeFromFull_r && fr.sclkFall && cnt == `APMS_CNT_LAST)
            begin
               waking_r <= 1'b0; // R1
               awake_r  <= 1'b1;
            end
         end
      end
   end

   // Sampler: held from select fall, back to tracking late in a normal frame,
   // or on the very first serial edge when the frame is a wake-up frame.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         trackActive    <= 1'b1; // R13
         trackPending_r <= 1'b0;
      end
      else if (clkEn)
      begin
         if (fr.selFall)
         begin
            trackActive    <= 1'b0;
            trackPending_r <= (mode_r != MODE_NORMAL);
         end
         else if (trackPending_r && (fr.sclkFall || fr.sclkRise))
         begin
            trackActive    <= 1'b1; // R3
            trackPending_r <= 1'b0;
         end
         else if (fr.selRise)
         begin
            trackActive    <= (modeNxt == MODE_NORMAL);
            trackPending_r <= 1'b0;
         end
         else if (fr.sclkRise && cnt >= `APMS_CNT_TRACK)
            trackActive <= 1'b1;
      end
   end

   // Serial result: first zero at select fall, one bit per falling edge after, up to the fifteenth; the sixteenth releases the line.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         word_r          <= '0;
         serialResultOut <= 1'b0;
         serialResultOe  <= 1'b0;
      end
      else if (clkEn)
      begin
         if (fr.selFall)
         begin
            word_r          <= {`APMS_LEAD_ZEROS, analogSample};
            serialResultOut <= 1'b0;
            serialResultOe  <= 1'b1;
         end
         else if (fr.selRise)
            serialResultOe <= 1'b0; // R14 R15 R17
         else if (fr.selLow && fr.sclkFall && serialResultOe)
         begin
            if (cnt == `APMS_CNT_LAST)
               serialResultOe <= 1'b0; // R17 R6
            else
               serialResultOut <= word_r[`APMS_BIT_IDX_W'(`APMS_CNT_LAST - cnt - 5'h01)];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         powerMode    <= POWERUP_MODE;
         fullyPowered <= (POWERUP_MODE == MODE_NORMAL);
      end
      else if (clkEn)
      begin
         powerMode    <= mode_r;
         fullyPowered <= (mode_r == MODE_NORMAL) && awake_r;
      end
   end

   frame_release_a: assert property (@(posedge clock) disable iff (rst) // R17
      clkEn && !fr.selFall && fr.selLow && fr.sclkFall && cnt == `APMS_CNT_LAST
      && serialResultOe
      |=> !serialResultOe)
      else $error("data line not released on edge sixteen");

   abort_release_a: assert property (@(posedge clock) disable iff (rst) // R14
      clkEn && fr.selRise |=> !serialResultOe)
      else $error("data line not released on select rise");

   partial_entry_a: assert property (@(posedge clock) disable iff (rst) // R15
      clkEn && fr.selRise && mode_r == MODE_NORMAL && cnt >= `APMS_CNT_POWERDOWN
      && cnt < `APMS_CNT_KEEP |=> mode_r == MODE_PARTIAL ##1 powerMode == MODE_PARTIAL)
      else $error("abort in window did not enter partial power-down");

   full_entry_a: assert property (@(posedge clock) disable iff (rst) // R5
      clkEn && fr.selRise && mode_r == MODE_PARTIAL && cnt >= `APMS_CNT_POWERDOWN
      && cnt < `APMS_CNT_KEEP |=> mode_r == MODE_FULL && !awake_r)
      else $error("second abort did not enter full power-down");

   glitch_keep_a: assert property (@(posedge clock) disable iff (rst) // R16
      clkEn && fr.selRise && cnt < `APMS_CNT_POWERDOWN |=> mode_r == $past(mode_r))
      else $error("early select rise changed the mode");

   keep_powered_a: assert property (@(posedge clock) disable iff (rst) // R14
      clkEn && fr.selRise && cnt >= `APMS_CNT_KEEP |=> mode_r == MODE_NORMAL)
      else $error("late select rise did not give normal mode");

   track_wake_a: assert property (@(posedge clock) disable iff (rst) // R3
      clkEn && trackPending_r && !fr.selFall && (fr.sclkFall || fr.sclkRise)
      |=> trackActive)
      else $error("sampler not tracking after first wake edge");

   partial_wake_a: assert property (@(posedge clock) disable iff (rst) // R1
      clkEn && fr.selFall && mode_r == MODE_PARTIAL
      |-> ##[1:PART_WAKE_LIMIT] (awake_r || fr.selRise))
      else $error("partial wake took longer than one microsecond");

   full_wake_a: assert property (@(posedge clock) disable iff (rst) // R8
      clkEn && waking_r && wakeFromFull_r && wakeTimer_r < PART_TGT |=> !awake_r)
      else $error("full wake finished too early");

   reset_track_a: assert property (@(posedge clock) // R13
      rst |=> trackActive && !serialResultOe)
      else $error("sampler not tracking after reset");

endmodule // apms_power_sequencer

`default_nettype wire

// file: design/apms_regs.svh
`ifndef APMS_REGS_SVH
`define APMS_REGS_SVH

// Falling-edge counts that split a frame into its abort windows.
`define APMS_CNT_W          5
`define APMS_CNT_POWERDOWN  5'h02
`define APMS_CNT_KEEP       5'h0A
`define APMS_CNT_TRACK      5'h0D
`define APMS_CNT_LAST       5'h0F
`define APMS_CNT_FRAME      5'h10

// Frame word: leading zeros above the sample.
`define APMS_WORD_W         16
`define APMS_SAMPLE_W       12
`define APMS_LEAD_ZEROS     4'h0
`define APMS_BIT_IDX_W      4

// Wake times in their own units and the system clock rate.
`define APMS_CLK_MHZ        100
`define APMS_PARTIAL_WAKE_NS 1000
`define APMS_FULL_WAKE_US   650
`define APMS_TIMER_W        17

`endif

// file: test/apms_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module apms_host_model
(
   input  wire logic clock,
   input  wire logic dataIn,
   output var  logic selN,
   output var  logic sclk
);
   // The serial clock stands still high outside frames.
   initial
   begin
      selN = 1'b1;
      sclk = 1'b1;
   end

   task automatic half();
      repeat (8) @(posedge clock);
      #1;
   endtask

   // One frame with nFalls serial clock falls; each bit is taken before the next fall.
   task automatic frame(input int nFalls, output logic [15:0] word);
      int k;
      word = 16'hFFFF;
      selN = 1'b0;
      half();
      for (k = 0; k < nFalls; k++)
      begin
         if (k < 16) word[15-k] = dataIn;
         sclk = 1'b0;
         half();
         sclk = 1'b1;
         half();
      end
      selN = 1'b1;
      half();
   endtask
endmodule // apms_host_model

`default_nettype wire

// file: test/apms_power_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module apms_power_sequencer_tb;
   import apms_pkg::*;
   localparam int WAKE = 300;
   logic        clock, rst, clkEn, selN, sclk, dOut, dOe, fullyPowered, trackActive;
   logic        dataLine;
   logic [11:0] sample;
   apms_mode_t  powerMode;
   logic [15:0] word;
   int          errTotal, cmpCount, cycles;

   // A released line shows the inverse of its last value, so stale data cannot pass.
   assign dataLine = dOe ? dOut : ~dOut;

   apms_power_sequencer #(.POWERUP_MODE(MODE_NORMAL), .FULL_WAKE_CYCLES(WAKE)) uut
   (
      .clock(clock), .rst(rst), .clkEn(clkEn), .selectPinN(selN),
      .serialClkPin(sclk), .analogSample(sample), .serialResultOut(dOut),
      .serialResultOe(dOe), .powerMode(powerMode), .fullyPowered(fullyPowered),
      .trackActive(trackActive)
   );
   apms_host_model host (.clock(clock), .dataIn(dataLine), .selN(selN), .sclk(sclk));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmpCount++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
         errTotal++;
      end
   endtask

   task automatic finish_test();
      $display("compares %0d errors %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic after_reset();
      check("mode", 16'(powerMode), 16'(MODE_NORMAL));
      check("track", 16'(trackActive), 16'h0001);
      check("oe", 16'(dOe), 16'h0000);
   endtask

   task automatic full_frame();
      sample = 12'hA5C;
      host.frame(16, word);
      check("word", word, {4'h0, 12'hA5C});
      check("oe", 16'(dOe), 16'h0000);
      check("mode", 16'(powerMode), 16'(MODE_NORMAL));
   endtask

   task automatic short_abort();
      host.frame(1, word);
      check("mode", 16'(powerMode), 16'(MODE_NORMAL));
   endtask

   // A window abort while the clock enable is low must leave every state untouched.
   task automatic frozen_frame();
      clkEn = 1'b0;
      fork
         host.frame(2, word);
         begin
            repeat (14) @(posedge clock);
            #2;
            check("oe", 16'(dOe), 16'h0000);
         end
      join
      clkEn = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      check("mode", 16'(powerMode), 16'(MODE_NORMAL));
      check("track", 16'(trackActive), 16'h0001);
   endtask

   task automatic keep_abort();
      sample = 12'h3C7;
      host.frame(12, word);
      check("word", word[15:4], {4'h0, 8'h3C});
      check("oe", 16'(dOe), 16'h0000);
      check("mode", 16'(powerMode), 16'(MODE_NORMAL));
   endtask

   task automatic enter_partial();
      host.frame(2, word);
      check("mode", 16'(powerMode), 16'(MODE_PARTIAL));
      check("oe", 16'(dOe), 16'h0000);
      check("track", 16'(trackActive), 16'h0000);
   endtask

   task automatic partial_glitch();
      fork
         host.frame(1, word);
         begin
            repeat (14) @(posedge clock);
            #2;
            check("track", 16'(trackActive), 16'h0001);
         end
      join
      check("mode", 16'(powerMode), 16'(MODE_PARTIAL));
   endtask

   task automatic enter_full();
      host.frame(9, word);
      check("mode", 16'(powerMode), 16'(MODE_FULL));
      check("ready", 16'(fullyPowered), 16'h0000);
   endtask

   task automatic wake_full();
      host.frame(10, word);
      check("mode", 16'(powerMode), 16'(MODE_NORMAL));
      check("ready", 16'(fullyPowered), 16'h0000);
      repeat (WAKE) @(posedge clock);
      #2;
      check("ready", 16'(fullyPowered), 16'h0001);
   endtask

   task automatic wake_partial();
      host.frame(5, word);
      check("mode", 16'(powerMode), 16'(MODE_PARTIAL));
      host.frame(16, word);
      check("mode", 16'(powerMode), 16'(MODE_NORMAL));
      check("ready", 16'(fullyPowered), 16'h0001);
      check("oe", 16'(dOe), 16'h0000);
   endtask

   // The whole sequence needs about 1700 cycles.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         errTotal++;
         finish_test();
      end
   end

   initial
   begin
      errTotal = 0;
      cmpCount = 0;
      cycles = 0;
      rst = 1'b1;
      clkEn = 1'b1;
      sample = 12'h000;
      repeat (10) @(posedge clock);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      after_reset();
      full_frame();
      short_abort();
      frozen_frame();
      keep_abort();
      enter_partial();
      partial_glitch();
      enter_full();
      wake_full();
      wake_partial();
      finish_test();
   end
endmodule // apms_power_sequencer_tb

`default_nettype wire
